/* File: logic/dual_gpio_port_ab.sv */
// Two 8-bit GPIO ports, pull-ups on port A and analog override on port B, behind a Wishbone slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module dual_gpio_port_ab (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [7:0] port_a_pin_i,
  output logic [7:0] port_a_pin_o,
  output logic [7:0] port_a_pin_oe_o,
  output logic [7:0] port_a_pullup_o,
  output logic [7:0] keypad_interrupt_inputs_o,
  input wire logic [7:0] port_b_pin_i,
  output logic [7:0] port_b_pin_o,
  output logic [7:0] port_b_pin_oe_o,
  input wire logic [7:0] analog_channel_select_i,
  output logic [7:0] analog_channel_pins_o
);

  // ==================================================================
  // Register state
  logic [7:0] a_latch_reg;
  logic [7:0] b_latch_reg;
  logic [7:0] a_dir_reg;
  logic [7:0] b_dir_reg;
  logic [7:0] a_pue_reg;
  logic [7:0] a_meta_reg;
  logic [7:0] a_sync_reg;
  logic [7:0] b_meta_reg;
  logic [7:0] b_sync_reg;
  logic [7:0] sel_meta_reg;
  logic [7:0] sel_sync_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ==================================================================
  // Bus decode
  // Single-cycle ack: a fresh request is answered one edge after it appears
  wire req = cyc_i && stb_i && !ack_reg;
  wire wr_lane0 = req && we_i && sel_i[0];
  wire hit_a_data = (adr_i == gpio_pkg::off_a_data);
  wire hit_b_data = (adr_i == gpio_pkg::off_b_data);
  wire hit_a_dir = (adr_i == gpio_pkg::off_a_dir);
  wire hit_b_dir = (adr_i == gpio_pkg::off_b_dir);
  wire hit_a_pue = (adr_i == gpio_pkg::off_a_pue);

  // ==================================================================
  // Read data mux
  // latch or pin
  wire [7:0] a_read = (a_dir_reg & a_latch_reg) | (~a_dir_reg & a_sync_reg);
  wire [7:0] b_read = (b_dir_reg & b_latch_reg) | (~b_dir_reg & b_sync_reg);
  wire [7:0] rd_byte = hit_a_data ? a_read :
                       hit_b_data ? b_read :
                       hit_a_dir ? a_dir_reg :
                       hit_b_dir ? b_dir_reg :
                       hit_a_pue ? a_pue_reg : 8'h00;
  wire any_hit = hit_a_data || hit_b_data || hit_a_dir || hit_b_dir || hit_a_pue;
  wire [31:0] rdata_next = any_hit ? {24'h000000, rd_byte} : gpio_pkg::unmapped_read;

  // ==================================================================
  // Data latches; no reset, contents survive it
  // latch always written
  always_ff @(posedge clk_i) begin
    if (wr_lane0 && hit_a_data) begin
      a_latch_reg <= dat_i[7:0];
    end
    if (wr_lane0 && hit_b_data) begin
      b_latch_reg <= dat_i[7:0];
    end
  end

  // Direction and pull-up registers
  // reset clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_dir_reg <= gpio_pkg::dir_reset;
      b_dir_reg <= gpio_pkg::dir_reset;
      a_pue_reg <= gpio_pkg::pue_reset;
    end else begin
      if (wr_lane0 && hit_a_dir) begin
        a_dir_reg <= dat_i[7:0];
      end
      if (wr_lane0 && hit_b_dir) begin
        b_dir_reg <= dat_i[7:0];
      end
      if (wr_lane0 && hit_a_pue) begin
        a_pue_reg <= dat_i[7:0];
      end
    end
  end

  // Two-flop synchronisers for pins and the converter select
  // synchronous sampling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_meta_reg <= 8'h00;
      a_sync_reg <= 8'h00;
      b_meta_reg <= 8'h00;
      b_sync_reg <= 8'h00;
      sel_meta_reg <= 8'h00;
      sel_sync_reg <= 8'h00;
    end else begin
      a_meta_reg <= port_a_pin_i;
      a_sync_reg <= a_meta_reg;
      b_meta_reg <= port_b_pin_i;
      b_sync_reg <= b_meta_reg;
      sel_meta_reg <= analog_channel_select_i;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  // Bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      rdata_reg <= req ? rdata_next : rdata_reg;
    end
  end

  // ==================================================================
  // Pin drive
  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;
  assign port_a_pin_oe_o = a_dir_reg;
  assign port_a_pin_o = a_latch_reg;
  assign port_a_pullup_o = a_pue_reg & ~a_dir_reg;
  // synchronised pins go to the keypad block, which applies its own enables
  assign keypad_interrupt_inputs_o = a_sync_reg;
  // selected channel forced to input, others digital
  assign port_b_pin_oe_o = b_dir_reg & ~sel_sync_reg;
  assign port_b_pin_o = b_latch_reg;
  assign analog_channel_pins_o = sel_sync_reg;

  // ==================================================================
  // Assertions
  // These watch only what the block itself drives; the bench's signals
  // appear as causes of implications and, through $past, in the write, select and synchroniser checks

  // Qualifier for checks that look back across a reset release
  logic past_valid_reg;
  always_ff @(posedge clk_i) begin
    past_valid_reg <= !rst_i;
  end

  // Latch-written flags; the latches power up unknown, so the
  // keep-through-reset checks only start once software gave a value.
  // They are never reset on purpose: a mid-run reset must still be watched.
  logic a_set_reg = 1'b0;
  logic b_set_reg = 1'b0;
  always_ff @(posedge clk_i) begin
    if (wr_lane0 && hit_a_data) begin
      a_set_reg <= 1'b1;
    end
    if (wr_lane0 && hit_b_data) begin
      b_set_reg <= 1'b1;
    end
  end

  // ==================================================================
  // Named steps of a bus access
  sequence wr_a_dir_s;
    wr_lane0 && hit_a_dir;
  endsequence

  sequence wr_b_dir_s;
    wr_lane0 && hit_b_dir;
  endsequence

  sequence wr_a_pue_s;
    wr_lane0 && hit_a_pue;
  endsequence

  sequence rd_a_s;
    req && !we_i && hit_a_data;
  endsequence

  sequence rd_b_s;
    req && !we_i && hit_b_data;
  endsequence

  sequence rd_none_s;
    req && !we_i && !any_hit;
  endsequence

  // Registered answer: one high cycle, then low again
  sequence answer_s;
    ack_o ##1 !ack_o;
  endsequence

  // ==================================================================
  // Reset behaviour
  dir_a_reset_a: assert property (@(posedge clk_i) rst_i |=> a_dir_reg == 8'h00)
    else $error("port a direction not cleared by reset");
  dir_b_reset_a: assert property (@(posedge clk_i) rst_i |=> b_dir_reg == 8'h00)
    else $error("port b direction not cleared by reset");
  pue_reset_a: assert property (@(posedge clk_i) rst_i |=> port_a_pullup_o == 8'h00)
    else $error("pull-ups not cleared by reset");
  latch_keep_a: assert property (@(posedge clk_i) rst_i && a_set_reg && !wr_lane0 |=> $stable(a_latch_reg))
    else $error("port a latch changed by reset");
  latch_b_keep_a: assert property (@(posedge clk_i) rst_i && b_set_reg && !wr_lane0 |=> $stable(b_latch_reg))
    else $error("port b latch changed by reset");

  // ==================================================================
  // Register writes
  latch_write_a: assert property (@(posedge clk_i) wr_lane0 && hit_a_data |=> a_latch_reg == $past(dat_i[7:0]))
    else $error("port a latch write lost");
  latch_b_write_a: assert property (@(posedge clk_i) wr_lane0 && hit_b_data |=> b_latch_reg == $past(dat_i[7:0]))
    else $error("port b latch write lost");
  dir_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_a_dir_s |=> port_a_pin_oe_o == $past(dat_i[7:0]))
    else $error("port a driver does not follow direction");
  dir_b_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_b_dir_s |=> port_b_pin_oe_o == ($past(dat_i[7:0]) & ~sel_sync_reg))
    else $error("port b driver does not follow direction");

  // ==================================================================
  // Pull-ups
  pullup_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) (port_a_pullup_o & a_dir_reg) == 8'h00)
    else $error("pull-up active on output pin");
  pullup_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_a_pue_s |=> port_a_pullup_o == ($past(dat_i[7:0]) & ~a_dir_reg))
    else $error("pull-up does not follow its enable");

  // ==================================================================
  // Converter override
  analog_ovr_a: assert property (@(posedge clk_i) disable iff (rst_i) (port_b_pin_oe_o & sel_sync_reg) == 8'h00)
    else $error("selected analog pin driven");
  digital_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((port_b_pin_oe_o ^ b_dir_reg) & ~sel_sync_reg) == 8'h00)
    else $error("unselected pin left digital control");
  analog_sel_a: assert property (@(posedge clk_i) disable iff (rst_i || !past_valid_reg)
    ##2 analog_channel_pins_o == $past(analog_channel_select_i, 2))
    else $error("converter select not handed on");

  // ==================================================================
  // Reads
  read_a_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_a_s |=> ack_o && dat_o[7:0] == (($past(a_dir_reg) & $past(a_latch_reg)) |
    (~$past(a_dir_reg) & $past(a_sync_reg))))
    else $error("port a read mux wrong");
  read_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_b_s |=> dat_o[7:0] == $past(b_read))
    else $error("port b read mux wrong");
  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_none_s |=> dat_o == gpio_pkg::unmapped_read)
    else $error("unmapped read not zero");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> answer_s)
    else $error("bus answer not a single pulse");

  // ==================================================================
  // Synchronisers
  // Two flops of lag on every asynchronous input; a shorter path would
  // let a metastable level reach the read mux
  sync_pin_a: assert property (@(posedge clk_i) disable iff (rst_i || !past_valid_reg)
    ##2 a_sync_reg == $past(port_a_pin_i, 2))
    else $error("pin synchroniser depth wrong");
  sync_pin_b_a: assert property (@(posedge clk_i) disable iff (rst_i || !past_valid_reg)
    ##2 b_sync_reg == $past(port_b_pin_i, 2))
    else $error("port b synchroniser depth wrong");
  keypad_feed_a: assert property (@(posedge clk_i) disable iff (rst_i || !past_valid_reg)
    ##2 keypad_interrupt_inputs_o == $past(port_a_pin_i, 2))
    else $error("keypad inputs do not follow pins");

endmodule

/* File: logic/gpio_pkg.sv */
// Package of register offsets, widths and reset values for the dual GPIO port
//
// Notes on behaviour
// - First port data latch, reset leaves it.
// - Second port data latch, reset leaves it.
// - First port direction one enables driver.
// - Second port direction one enables driver.
// - Reset clears first port direction bits.
// - Reset clears second port direction bits.
// - First port read: latch if output, else pin.
// - Second port read: latch if output, else pin.
// - Data writes always update latch.
// - Eight pull-up enables, reset to zero.
// - Pull-up only when enabled and input.
// - Enabled input pulled high, else high-impedance.
// - First port pins feed keypad interrupt inputs.
// - Selected converter channel forces analog input.
// - Unselected second port pins stay digital.
package gpio_pkg;
  localparam int port_width = 8;
  localparam int addr_width = 32;
  localparam int data_width = 32;
  // Byte addresses of the five registers, one byte each on the low lane
  localparam logic [31:0] off_a_data = 32'h0000_0000;
  localparam logic [31:0] off_b_data = 32'h0000_0001;
  localparam logic [31:0] off_a_dir = 32'h0000_0004;
  localparam logic [31:0] off_a_pue = 32'h0000_000d;
  // Second port direction address is a free choice, clear of the others
  localparam logic [31:0] off_b_dir = 32'h0000_0008;
  localparam logic [7:0] dir_reset = 8'h00;
  localparam logic [7:0] pue_reset = 8'h00;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;
endpackage

/* File: tb/pin_model.sv */
// Behavioural model of the external pins of one port
`timescale 1ns/1ps
module pin_model (
  input wire logic [7:0] oe_i,
  input wire logic [7:0] drive_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] level_o
);
  // Driven pins follow the port, pulled-up inputs read high, else the outside level
  assign level_o = (oe_i & drive_i) | (~oe_i & pullup_i) | (~oe_i & ~pullup_i & ext_i);
endmodule

/* File: tb/tb_top.sv */
// Register-level testbench for the dual GPIO port block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
  logic [3:0] sel_i = 4'h0;
  logic ack_o;
  logic [7:0] a_pin, a_drv, a_oe, a_pu, kbi, b_pin, b_drv, b_oe, an_pins;
  logic [7:0] ext_a = 8'h00, ext_b = 8'h00, an_sel = 8'h00;
  int mismatches = 0;
  int check_count = 0;
  always #2.5 clk_i = ~clk_i;
  dual_gpio_port_ab u_dual_gpio_port_ab (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .port_a_pin_i(a_pin), .port_a_pin_o(a_drv), .port_a_pin_oe_o(a_oe), .port_a_pullup_o(a_pu),
    .keypad_interrupt_inputs_o(kbi), .port_b_pin_i(b_pin), .port_b_pin_o(b_drv), .port_b_pin_oe_o(b_oe),
    .analog_channel_select_i(an_sel), .analog_channel_pins_o(an_pins));
  pin_model u_pin_a (.oe_i(a_oe), .drive_i(a_drv), .pullup_i(a_pu), .ext_i(ext_a), .level_o(a_pin));
  pin_model u_pin_b (.oe_i(b_oe), .drive_i(b_drv), .pullup_i(8'h00), .ext_i(ext_b), .level_o(b_pin));
  // ==========================================
  // Verdict and bus tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic cycle; ack is sampled at the edge, before that edge's updates land
  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 1'b1, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e, input string n);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk(n, {24'h0, e}, q);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(gpio_pkg::off_a_dir, 8'h00, "dir_a");
    rd(gpio_pkg::off_b_dir, 8'h00, "dir_b");
    rd(gpio_pkg::off_a_pue, 8'h00, "pullup_en");
    rd(32'h0000_0100, 8'h00, "unmapped");
    $display("test reset values done");
    // Latch written while input must not show on reads
    ext_a <= 8'ha5;
    wr(gpio_pkg::off_a_data, 8'h3c);
    repeat (4) @(posedge clk_i);
    rd(gpio_pkg::off_a_data, 8'ha5, "a_input");
    chk("keypad", 32'ha5, {24'h0, kbi});
    // Output low nibble drops its pull-ups, high nibble reads pulled high
    ext_a <= 8'h00;
    wr(gpio_pkg::off_a_pue, 8'hff);
    wr(gpio_pkg::off_a_dir, 8'h0f);
    repeat (4) @(posedge clk_i);
    chk("pullup", 32'hf0, {24'h0, a_pu});
    chk("oe_a", 32'h0f, {24'h0, a_oe});
    rd(gpio_pkg::off_a_data, 8'hfc, "a_mixed");
    $display("test port a done");
    // Latch first, then direction, to avoid a glitch
    wr(gpio_pkg::off_b_data, 8'h5a);
    ext_b <= 8'h0f;
    wr(gpio_pkg::off_b_dir, 8'hf0);
    repeat (4) @(posedge clk_i);
    rd(gpio_pkg::off_b_data, 8'h5f, "b_mixed");
    chk("oe_b", 32'hf0, {24'h0, b_oe});
    an_sel <= 8'h10;
    repeat (4) @(posedge clk_i);
    chk("oe_b_analog", 32'he0, {24'h0, b_oe});
    chk("analog", 32'h10, {24'h0, an_pins});
    $display("test port b done");
    // Mid-run reset keeps both latches
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("latch_a", 32'h3c, {24'h0, a_drv});
    chk("latch_b", 32'h5a, {24'h0, b_drv});
    chk("oe_a_rst", 32'h00, {24'h0, a_oe});
    $display("test second reset done");
    end_of_test();
  end
endmodule
